// ===== pca_arbiter.sv
// projector control arbiter: standard select, white balance, ownership, ids
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module pca_arbiter
    import pca_pkg::*;
#(
    parameter logic [1:0] UNIT_INDEX = 2'h0
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic signal_is_pal,
    input wire logic discharge_upset,
    input wire logic remote_strobe,
    input wire logic [3:0] remote_key,
    input wire logic [15:0] remote_id,
    input wire logic rear_strobe,
    input wire logic [3:0] rear_op,
    output logic pal_mode,
    output logic [2:0] wb_sel,
    output logic [1:0] adjust_owner,
    output logic adjust_apply,
    output logic standby,
    output logic link_forward_en,
    output logic nvm_save,
    output logic [2:0] active_input
);
    localparam logic [7:0] ID_RESET = PCA_ID_BASE + {6'h00, UNIT_INDEX};

    // pins
    logic [27:0] pin_s;
    pca_sync #(.W(28)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d({signal_is_pal, discharge_upset, remote_strobe, remote_key, remote_id, rear_strobe, rear_op}),
        .q(pin_s)
    );
    wire sig_pal_s = pin_s[27];
    wire dis_s = pin_s[26];
    wire rem_s = pin_s[25];
    wire [3:0] rem_key_s = pin_s[24:21];
    wire [15:0] rem_id_s = pin_s[20:5];
    wire rear_s = pin_s[4];
    wire [3:0] rear_op_s = pin_s[3:0];

    logic dis_prev_reg, rem_prev_reg, rear_prev_reg;
    pca_settings_t settings_reg, settings_next, saved_reg;
    pca_src_t owner_reg;
    logic [7:0] id_reg;
    logic id_valid_reg, standby_reg, pal_mode_reg, nvm_save_reg, adjust_apply_reg, link_fwd_reg;
    logic [2:0] wb_sel_reg;
    logic host_pend_reg;
    pca_cmd_t host_cmd_reg;

    // bus slave state
    logic aw_hold_reg, w_hold_reg, awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg, rdata_reg;
    logic [3:0] w_strb_reg;
    logic [1:0] bresp_reg, rresp_reg;

    wire aw_fire = s_axi_awvalid && awready_reg;
    wire w_fire = s_axi_wvalid && wready_reg;
    wire ar_fire = s_axi_arvalid && arready_reg;
    wire wr_commit = aw_hold_reg && w_hold_reg && !bvalid_reg;
    wire aw_hold_next = wr_commit ? 1'b0 : (aw_fire ? 1'b1 : aw_hold_reg);
    wire w_hold_next = wr_commit ? 1'b0 : (w_fire ? 1'b1 : w_hold_reg);
    wire rvalid_next = ar_fire ? 1'b1 : (s_axi_rready ? 1'b0 : rvalid_reg);
    wire wr_ctrl = wr_commit && aw_addr_reg == PCA_OFF_CTRL;
    wire wr_cmd = wr_commit && aw_addr_reg == PCA_OFF_CMD;
    wire wr_mapped = aw_addr_reg == PCA_OFF_CTRL || aw_addr_reg == PCA_OFF_CMD
        || aw_addr_reg == PCA_OFF_STATUS || aw_addr_reg == PCA_OFF_SAVED;
    wire rd_mapped = s_axi_araddr == PCA_OFF_CTRL || s_axi_araddr == PCA_OFF_CMD
        || s_axi_araddr == PCA_OFF_STATUS || s_axi_araddr == PCA_OFF_SAVED;
    wire [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    wire [15:0] ctrl_wr_val = (settings_reg & ~wmask[15:0]) | (w_data_reg[15:0] & wmask[15:0]);

    pca_status_t status_w;
    assign status_w = '{rsv: 13'h0000, input_sel: settings_reg.input_sel, id: id_reg, wb_sel: wb_sel_reg,
        id_valid: id_valid_reg, standby: standby_reg, owner: owner_reg, pal_mode: pal_mode_reg};
    wire [31:0] rd_data = (s_axi_araddr == PCA_OFF_CTRL) ? {16'h0000, settings_reg}
        : (s_axi_araddr == PCA_OFF_STATUS) ? status_w
        : (s_axi_araddr == PCA_OFF_SAVED) ? {16'h0000, saved_reg} : 32'h0000_0000;

    // event selection: rear panel first, then host, then remote
    wire rear_ev = rear_s && !rear_prev_reg;
    wire rem_ev = rem_s && !rem_prev_reg;
    wire dis_ev = dis_s && !dis_prev_reg;
    wire host_sel = host_pend_reg && !rear_ev;
    wire rem_sel = rem_ev && !rear_ev && !host_pend_reg;
    wire ev_valid = rear_ev || host_sel || rem_sel;
    wire pca_src_t ev_src = rear_ev ? PCA_SRC_REAR : (host_sel ? PCA_SRC_HOST : PCA_SRC_REMOTE);
    wire [3:0] ev_op_raw = rear_ev ? rear_op_s : (host_sel ? host_cmd_reg.op : rem_key_s);
    wire pca_op_t ev_op = pca_op_t'(ev_op_raw);
    wire ev_idp = host_sel && host_cmd_reg.id_present;
    wire [7:0] ev_c_hi = host_sel ? host_cmd_reg.c_hi : rem_id_s[15:8];
    wire [7:0] ev_c_lo = host_sel ? host_cmd_reg.c_lo : rem_id_s[7:0];
    wire [2:0] ev_arg = host_sel ? host_cmd_reg.arg : settings_reg.input_sel + 3'h1;

    logic m_hit, m_set_ok;
    logic [7:0] m_set_val;
    pca_id_match u_match (
        .own_id(id_reg),
        .c_hi(ev_c_hi),
        .c_lo(ev_c_lo),
        .hit(m_hit),
        .set_ok(m_set_ok),
        .set_val(m_set_val)
    );

    // filtering of the selected event
    wire id_ok = !ev_idp || (id_valid_reg && m_hit);
    wire stby_ok = ev_src != PCA_SRC_REMOTE || !standby_reg || ev_op == PCA_OP_POWER_OFF
        || ev_op == PCA_OP_CM1 || ev_op == PCA_OP_CM2 || ev_op == PCA_OP_EXIT_ADJ
        || ev_op == PCA_OP_ID_SELECT;
    wire adj_ok = ev_op != PCA_OP_ADJUST || owner_reg == ev_src;
    wire set_go = !id_valid_reg && m_set_ok;
    wire clr_go = id_valid_reg && m_hit;
    wire op_ok = (ev_op == PCA_OP_ID_SET) ? set_go : (ev_op == PCA_OP_ID_CLEAR) ? clr_go
        : (ev_op == PCA_OP_ID_SELECT) ? 1'b1 : id_ok;
    wire ev_go = ev_valid && stby_ok && adj_ok && op_ok;
    wire own_exit = ev_go && ev_op == PCA_OP_EXIT_ADJ && owner_reg == ev_src;
    wire rear_kick = rear_ev && owner_reg != PCA_SRC_NONE;
    // mains loss saves nothing, so only these paths commit settings
    wire save_now = (ev_go && ev_op == PCA_OP_POWER_OFF) || own_exit || rear_kick;
    wire sel_hit = id_valid_reg && m_hit;

    always_comb begin
        settings_next = settings_reg;
        if (wr_ctrl) begin
            settings_next = pca_settings_t'(ctrl_wr_val);
        end
        if (ev_go) begin
            case (ev_op)
                PCA_OP_CM1: settings_next.colour_mode = 1'b0;
                PCA_OP_CM2: settings_next.colour_mode = 1'b1;
                PCA_OP_SEL_INPUT: settings_next.input_sel = ev_arg;
                default: ;
            endcase
        end
        // upset wins: input snaps back to the last committed value
        if (dis_ev) begin
            settings_next.input_sel = saved_reg.input_sel;
        end
    end

    // standard select is re-evaluated every cycle, no power cycle needed
    wire std_pal = (settings_reg.std_sel == PCA_STD_AUTO) ? sig_pal_s
        : (settings_reg.std_sel == PCA_STD_PAL);
    // user memories 0..3 by colour mode and input, factory 4..5 fixed
    wire [2:0] wb_user = {1'b0, settings_reg.colour_mode, settings_reg.input_sel[0]};
    wire [2:0] wb_fact = PCA_WB_FACTORY_BASE + {2'b00, settings_reg.reexpose};
    wire [2:0] wb_next = settings_reg.factory_wb ? wb_fact : wb_user;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dis_prev_reg <= 1'b0;
            rem_prev_reg <= 1'b0;
            rear_prev_reg <= 1'b0;
            pal_mode_reg <= 1'b0;
            wb_sel_reg <= 3'h0;
        end else begin
            dis_prev_reg <= dis_s;
            rem_prev_reg <= rem_s;
            rear_prev_reg <= rear_s;
            pal_mode_reg <= std_pal;
            wb_sel_reg <= wb_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            settings_reg <= PCA_SETTINGS_RESET;
            saved_reg <= PCA_SETTINGS_RESET;
            nvm_save_reg <= 1'b0;
        end else begin
            settings_reg <= settings_next;
            nvm_save_reg <= save_now;
            if (save_now) begin
                saved_reg <= settings_reg;
            end
        end
    end

    // host command mailbox; a new write wins over the take
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            host_pend_reg <= 1'b0;
            host_cmd_reg <= 32'h0000_0000;
        end else if (wr_cmd) begin
            host_pend_reg <= 1'b1;
            host_cmd_reg <= w_data_reg;
        end else if (host_sel) begin
            host_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            owner_reg <= PCA_SRC_NONE;
            adjust_apply_reg <= 1'b0;
        end else begin
            adjust_apply_reg <= ev_go && ev_op == PCA_OP_ADJUST;
            if (rear_ev) begin
                owner_reg <= PCA_SRC_NONE;
            end else if (ev_go && ev_op == PCA_OP_ENTER_ADJ) begin
                owner_reg <= ev_src;
            end else if (own_exit || (ev_go && ev_op == PCA_OP_POWER_OFF)) begin
                owner_reg <= PCA_SRC_NONE;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            id_reg <= ID_RESET;
            id_valid_reg <= 1'b1;
            link_fwd_reg <= 1'b1;
            standby_reg <= 1'b0;
        end else begin
            if (ev_go && ev_op == PCA_OP_ID_SET) begin
                id_reg <= m_set_val;
                id_valid_reg <= 1'b1;
                link_fwd_reg <= 1'b1;
            end else if (ev_go && ev_op == PCA_OP_ID_CLEAR) begin
                id_valid_reg <= 1'b0;
                link_fwd_reg <= 1'b0;
            end
            if (ev_go && ev_op == PCA_OP_ID_SELECT) begin
                standby_reg <= !sel_hit;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= PCA_RESP_OKAY;
        end else begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            awready_reg <= !aw_hold_next;
            wready_reg <= !w_hold_next;
            if (aw_fire) begin
                aw_addr_reg <= s_axi_awaddr;
            end
            if (w_fire) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_commit) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_mapped ? PCA_RESP_OKAY : PCA_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= PCA_RESP_OKAY;
        end else begin
            rvalid_reg <= rvalid_next;
            arready_reg <= !rvalid_next;
            if (ar_fire) begin
                rdata_reg <= rd_data;
                rresp_reg <= rd_mapped ? PCA_RESP_OKAY : PCA_RESP_SLVERR;
            end
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign pal_mode = pal_mode_reg;
    assign wb_sel = wb_sel_reg;
    assign adjust_owner = owner_reg;
    assign adjust_apply = adjust_apply_reg;
    assign standby = standby_reg;
    assign link_forward_en = link_fwd_reg;
    assign nvm_save = nvm_save_reg;
    assign active_input = settings_reg.input_sel;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_std_auto;
        settings_reg.std_sel == PCA_STD_AUTO ##0 sig_pal_s |=> pal_mode_reg;
    endproperty
    a_std_auto: assert property (p_std_auto) else $error("auto standard not followed");
    property p_std_ntsc;
        settings_reg.std_sel == PCA_STD_NTSC |=> !pal_mode_reg;
    endproperty
    a_std_ntsc: assert property (p_std_ntsc) else $error("forced ntsc not held");
    property p_std_pal;
        settings_reg.std_sel == PCA_STD_PAL |=> pal_mode_reg;
    endproperty
    a_std_pal: assert property (p_std_pal) else $error("forced pal not held");
    property p_wb_user;
        !settings_reg.factory_wb |=> wb_sel_reg < PCA_WB_USER_COUNT;
    endproperty
    a_wb_user: assert property (p_wb_user) else $error("user wb index out of range");
    property p_host_take;
        host_sel && ev_go && ev_op == PCA_OP_ENTER_ADJ |=> owner_reg == PCA_SRC_HOST;
    endproperty
    a_host_take: assert property (p_host_take) else $error("host did not take adjust");
    property p_remote_blocked;
        owner_reg == PCA_SRC_HOST && rem_sel && ev_op == PCA_OP_ADJUST |=> !adjust_apply_reg;
    endproperty
    a_remote_blocked: assert property (p_remote_blocked) else $error("remote adjust not ignored");
    property p_rear_exit;
        rear_ev |=> owner_reg == PCA_SRC_NONE;
    endproperty
    a_rear_exit: assert property (p_rear_exit) else $error("rear switch did not exit adjust");
    property p_save_power;
        ev_go && ev_op == PCA_OP_POWER_OFF |=> nvm_save_reg && saved_reg == $past(settings_reg);
    endproperty
    a_save_power: assert property (p_save_power) else $error("power off did not save");
    property p_upset;
        dis_ev |=> settings_reg.input_sel == $past(saved_reg.input_sel);
    endproperty
    a_upset: assert property (p_upset) else $error("upset did not restore input");
    property p_clear_fwd;
        ev_go && ev_op == PCA_OP_ID_CLEAR |=> !link_fwd_reg && !id_valid_reg;
    endproperty
    a_clear_fwd: assert property (p_clear_fwd) else $error("cleared unit still forwards");
    c_host_enter: cover property (host_sel && ev_go && ev_op == PCA_OP_ENTER_ADJ);
    c_id_set: cover property (ev_go && ev_op == PCA_OP_ID_SET);
    c_standby: cover property (!standby_reg ##1 standby_reg);
endmodule // pca_arbiter

// ===== pca_pkg.sv
// shared constants and types of the projector control arbiter
package pca_pkg;
    localparam logic [7:0] PCA_OFF_CTRL = 8'h00;
    localparam logic [7:0] PCA_OFF_CMD = 8'h04;
    localparam logic [7:0] PCA_OFF_STATUS = 8'h08;
    localparam logic [7:0] PCA_OFF_SAVED = 8'h0C;
    localparam logic [1:0] PCA_RESP_OKAY = 2'h0;
    localparam logic [1:0] PCA_RESP_SLVERR = 2'h2;
    localparam logic [1:0] PCA_STD_AUTO = 2'h0;
    localparam logic [1:0] PCA_STD_NTSC = 2'h1;
    localparam logic [1:0] PCA_STD_PAL = 2'h2;
    localparam logic [7:0] PCA_ID_BASE = 8'h11;
    localparam logic [2:0] PCA_WB_USER_COUNT = 3'h4;
    localparam logic [2:0] PCA_WB_FACTORY_BASE = 3'h4;
    localparam logic [7:0] PCA_CHR_STAR = 8'h2A;
    localparam logic [7:0] PCA_CHR_ZERO = 8'h30;
    localparam logic [7:0] PCA_CHR_NINE = 8'h39;
    localparam logic [7:0] PCA_CHR_UP_A = 8'h41;
    localparam logic [7:0] PCA_CHR_UP_F = 8'h46;
    localparam logic [7:0] PCA_CHR_LO_A = 8'h61;
    localparam logic [7:0] PCA_CHR_LO_F = 8'h66;
    localparam logic [7:0] PCA_CHR_CASE = 8'h20;
    localparam logic [7:0] PCA_CHR_HEX_OFS = 8'h57;

    typedef enum logic [3:0] {
        PCA_OP_NONE, PCA_OP_ENTER_ADJ, PCA_OP_EXIT_ADJ, PCA_OP_POWER_OFF,
        PCA_OP_ID_SET, PCA_OP_ID_CLEAR, PCA_OP_CM1, PCA_OP_CM2,
        PCA_OP_SEL_INPUT, PCA_OP_ID_SELECT, PCA_OP_ADJUST
    } pca_op_t;

    typedef enum logic [1:0] {PCA_SRC_NONE, PCA_SRC_HOST, PCA_SRC_REMOTE, PCA_SRC_REAR} pca_src_t;

    typedef struct packed {
        logic reexpose;
        logic factory_wb;
        logic [2:0] input_sel;
        logic [1:0] conv_mem;
        logic [2:0] baud;
        logic video_mute;
        logic bright_link;
        logic periph_light;
        logic colour_mode;
        logic [1:0] std_sel;
    } pca_settings_t;
    localparam pca_settings_t PCA_SETTINGS_RESET = 16'h0000;

    typedef struct packed {
        logic [4:0] rsv_hi;
        logic [2:0] arg;
        logic [7:0] c_lo;
        logic [7:0] c_hi;
        logic [2:0] rsv_lo;
        logic id_present;
        logic [3:0] op;
    } pca_cmd_t;

    typedef struct packed {
        logic [12:0] rsv;
        logic [2:0] input_sel;
        logic [7:0] id;
        logic [2:0] wb_sel;
        logic id_valid;
        logic standby;
        logic [1:0] owner;
        logic pal_mode;
    } pca_status_t;
endpackage

// ===== pca_sync.sv
// two-stage synchroniser for the pin inputs
`timescale 1ns/100ps
module pca_sync #(
    parameter int unsigned W = 1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // pca_sync

// ===== pca_id_match.sv
// two-digit identifier decode and compare with wildcard
`timescale 1ns/100ps
module pca_id_match
    import pca_pkg::*;
(
    input wire logic [7:0] own_id,
    input wire logic [7:0] c_hi,
    input wire logic [7:0] c_lo,
    output logic hit,
    output logic set_ok,
    output logic [7:0] set_val
);
    logic [1:0] legal;
    logic [1:0] wild;
    logic [1:0] eq;

    genvar d;
    generate
        for (d = 0; d < 2; d++) begin : g_digit
            wire [7:0] ch = (d == 1) ? c_hi : c_lo;
            wire is_dig = (ch >= PCA_CHR_ZERO) && (ch <= PCA_CHR_NINE);
            wire is_up = (ch >= PCA_CHR_UP_A) && (ch <= PCA_CHR_UP_F);
            wire is_lo = (ch >= PCA_CHR_LO_A) && (ch <= PCA_CHR_LO_F);
            // fold case so that A-F and a-f decode alike
            wire [7:0] folded = is_up ? (ch | PCA_CHR_CASE) : ch;
            wire [7:0] dig8 = ch - PCA_CHR_ZERO;
            wire [7:0] hex8 = folded - PCA_CHR_HEX_OFS;
            wire [3:0] nib = is_dig ? dig8[3:0] : hex8[3:0];
            assign wild[d] = (ch == PCA_CHR_STAR);
            assign legal[d] = is_dig || is_up || is_lo;
            assign eq[d] = wild[d] || (legal[d] && nib == own_id[4*d +: 4]);
            assign set_val[4*d +: 4] = nib;
        end
    endgenerate

    assign hit = eq[0] && eq[1];
    assign set_ok = legal[0] && legal[1];
endmodule // pca_id_match

// ===== pca_remote_model.sv
// remote control model driving the key event pins
`timescale 1ns/100ps
module pca_remote_model (
    input wire logic clk_sys,
    input wire logic send,
    input wire logic [3:0] key,
    input wire logic [15:0] id,
    output logic remote_strobe,
    output logic [3:0] remote_key,
    output logic [15:0] remote_id
);
    int unsigned hold_cnt = 0;
    initial begin
        remote_strobe = 1'b0;
        remote_key = 4'h0;
        remote_id = 16'h0000;
    end
    // key and id settle a cycle ahead of the strobe; idle lines show no stale value
    always @(posedge clk_sys) begin
        if (send) begin
            remote_key <= key;
            remote_id <= id;
            hold_cnt <= 6;
        end else if (hold_cnt > 0) begin
            hold_cnt <= hold_cnt - 1;
            remote_strobe <= (hold_cnt > 1);
            if (hold_cnt == 1) begin
                remote_key <= ~remote_key;
                remote_id <= ~remote_id;
            end
        end
    end
endmodule // pca_remote_model

// ===== pca_arbiter_test.sv
// self-checking bench of the projector control arbiter
`timescale 1ns/100ps
module pca_arbiter_test
    import pca_pkg::*;
;
    logic clk_sys = 1'b0, rst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, signal_is_pal = 1'b0, discharge_upset = 1'b0;
    logic rear_strobe = 1'b0, rsend = 1'b0, saw_save = 1'b0, saw_apply = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF, rear_op = 4'h0, rkey = 4'h0, remote_key;
    logic [15:0] rid = 16'h0, remote_id;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, remote_strobe;
    logic pal_mode, adjust_apply, standby, link_forward_en, nvm_save;
    logic [1:0] s_axi_bresp, s_axi_rresp, adjust_owner, rr;
    logic [2:0] wb_sel, active_input;
    int errors = 0, cmp_count = 0;
    pca_arbiter #(.UNIT_INDEX(2'h0)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .signal_is_pal(signal_is_pal),
        .discharge_upset(discharge_upset), .remote_strobe(remote_strobe), .remote_key(remote_key),
        .remote_id(remote_id), .rear_strobe(rear_strobe), .rear_op(rear_op), .pal_mode(pal_mode),
        .wb_sel(wb_sel), .adjust_owner(adjust_owner), .adjust_apply(adjust_apply), .standby(standby),
        .link_forward_en(link_forward_en), .nvm_save(nvm_save), .active_input(active_input));
    pca_remote_model RCM (.clk_sys(clk_sys), .send(rsend), .key(rkey), .id(rid),
        .remote_strobe(remote_strobe), .remote_key(remote_key), .remote_id(remote_id));
    initial forever #50 clk_sys = ~clk_sys;
    // one-cycle pulses are latched so a fixed wait cannot miss them
    always @(posedge clk_sys) begin
        if (nvm_save === 1'b1) saw_save <= 1'b1;
        if (adjust_apply === 1'b1) saw_apply <= 1'b1;
    end
    task automatic final_report();
        if (errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("BAD %0t got %h expected %h", $time, got, exp);
            errors++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 40);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n >= 40) begin
            errors++;
            final_report();
        end
    endtask
    task automatic rdr(input logic [7:0] a);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 40);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n >= 40) begin
            errors++;
            final_report();
        end
    endtask
    task automatic ctl(input logic [31:0] d);
        wr(PCA_OFF_CTRL, d);
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic cmd(input logic [3:0] op, input logic [7:0] h, input logic [7:0] l);
        wr(PCA_OFF_CMD, {8'h00, l, h, 3'h0, (h != 8'h00), op});
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic rem(input logic [3:0] k, input logic [15:0] i);
        rkey <= k;
        rid <= i;
        rsend <= 1'b1;
        @(posedge clk_sys);
        rsend <= 1'b0;
        repeat (14) @(posedge clk_sys);
    endtask
    task automatic t_reset();
        rdr(PCA_OFF_STATUS);
        chk(rd, 32'h0000_1110);
        @(posedge clk_sys);
        rdr(8'h10);
        chk(rr, PCA_RESP_SLVERR);
        wr(8'h10, 32'h0000_FFFF);
        chk(rr, PCA_RESP_SLVERR);
        @(posedge clk_sys);
    endtask
    task automatic t_std();
        signal_is_pal <= 1'b1;
        ctl(32'h0);
        chk(pal_mode, 1'b1);
        ctl(32'h1);
        chk(pal_mode, 1'b0);
        signal_is_pal <= 1'b0;
        ctl(32'h2);
        chk(pal_mode, 1'b1);
        ctl(32'h0);
        chk(pal_mode, 1'b0);
    endtask
    task automatic t_wb();
        ctl(32'h4000);
        chk(wb_sel, 3'h4);
        ctl(32'hC000);
        chk(wb_sel, 3'h5);
        ctl(32'h1000);
        saw_save <= 1'b0;
        cmd(PCA_OP_CM2, 8'h00, 8'h00);
        rd = {29'h0, wb_sel};
        cmd(PCA_OP_POWER_OFF, 8'h00, 8'h00);
        chk({active_input, saw_save}, 4'h5);
        cmd(PCA_OP_CM1, 8'h00, 8'h00);
        chk(wb_sel != rd[2:0] && wb_sel < PCA_WB_USER_COUNT, 1'b1);
    endtask
    task automatic t_own();
        rem(PCA_OP_ENTER_ADJ, 16'h0);
        chk(adjust_owner, PCA_SRC_REMOTE);
        cmd(PCA_OP_ENTER_ADJ, 8'h00, 8'h00);
        chk(adjust_owner, PCA_SRC_HOST);
        saw_apply <= 1'b0;
        rem(PCA_OP_ADJUST, 16'h0);
        chk(saw_apply, 1'b0);
        rem(PCA_OP_ENTER_ADJ, 16'h0);
        chk(adjust_owner, PCA_SRC_REMOTE);
        cmd(PCA_OP_ADJUST, 8'h00, 8'h00);
        chk(saw_apply, 1'b0);
        rem(PCA_OP_ADJUST, 16'h0);
        chk(saw_apply, 1'b1);
        saw_save <= 1'b0;
        rem(PCA_OP_EXIT_ADJ, 16'h0);
        chk({adjust_owner, saw_save}, 3'h1);
        rdr(PCA_OFF_SAVED);
        chk(rd, 32'h1000);
        cmd(PCA_OP_ENTER_ADJ, 8'h00, 8'h00);
        saw_save <= 1'b0;
        rear_op <= PCA_OP_CM1;
        rear_strobe <= 1'b1;
        repeat (5) @(posedge clk_sys);
        rear_strobe <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk({adjust_owner, saw_save}, 3'h1);
    endtask
    task automatic t_save();
        saw_save <= 1'b0;
        ctl(32'h2800);
        chk({active_input, saw_save}, 4'hA);
        discharge_upset <= 1'b1;
        repeat (5) @(posedge clk_sys);
        discharge_upset <= 1'b0;
        repeat (5) @(posedge clk_sys);
        chk(active_input, 3'h2);
    endtask
    task automatic t_id();
        cmd(PCA_OP_ID_CLEAR, PCA_CHR_STAR, PCA_CHR_STAR);
        chk(link_forward_en, 1'b0);
        cmd(PCA_OP_ID_SET, 8'h33, 8'h61);
        rdr(PCA_OFF_STATUS);
        chk({link_forward_en, rd[15:8]}, 9'h13A);
        cmd(PCA_OP_ID_SET, 8'h34, 8'h34);
        rdr(PCA_OFF_STATUS);
        chk(rd[15:8], 8'h3A);
        cmd(PCA_OP_ENTER_ADJ, PCA_CHR_STAR, 8'h62);
        chk(adjust_owner, PCA_SRC_NONE);
        cmd(PCA_OP_ENTER_ADJ, 8'h33, PCA_CHR_STAR);
        chk(adjust_owner, PCA_SRC_HOST);
        saw_apply <= 1'b0;
        cmd(PCA_OP_ADJUST, 8'h33, 8'h41);
        chk(saw_apply, 1'b1);
        cmd(PCA_OP_EXIT_ADJ, 8'h33, 8'h41);
        chk(adjust_owner, PCA_SRC_NONE);
        rem(PCA_OP_ID_SELECT, 16'h3939);
        chk(standby, 1'b1);
        rem(PCA_OP_ID_SELECT, 16'h3341);
        chk(standby, 1'b0);
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_reset();
        t_std();
        t_wb();
        t_own();
        t_save();
        t_id();
        final_report();
    end
endmodule // pca_arbiter_test
